// *** logic/alu_pkg.sv ***
// Contract
// - Byte add, optional carry in, sets Z, C, N, V, H in one cycle.
// - Word add of a constant to high:low sets Z, C, N, V, S in two cycles.
// - Byte subtract, optional borrow, sets Z, C, N, V, H in one cycle.
// - Word subtract of a constant from high:low sets Z,C,N,V,S, two cycles.
// - AND with a register or constant sets only Z, N and V in one cycle.
// - OR with a register or constant sets only Z, N and V in one cycle.
// - XOR with the source sets only Z, N and V in one cycle.
// - 0xFF minus value sets Z,C,N,V; 0x00 minus it also sets H; one cycle.
// - Mask OR or AND with 0xFF minus mask sets Z, N, V in one cycle.
// - Plus one and minus one set only Z, N, V and keep carry, in one cycle.
// - Zero/sign check keeps the value and sets Z, N and V in one cycle.
// - Zero fill clears and sets Z, N, V; fill ones loads 0xFF, no flags.
// - Byte products fill the product pair, setting Z and C, in two cycles.
// - Fractional products are shifted left by one, set Z and C, two cycles.
`default_nettype none

package alu_pkg;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DEST = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_WORD_HI = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_PROD_LO = 8'h14;
    localparam logic [7:0] OFF_PROD_HI = 8'h18;
    localparam int CTRL_GO_BIT = 7;
    localparam int CTRL_BUSY_BIT = 6;
    localparam int CTRL_OP_W = 5;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] FLAGS_MASK = 8'h3F;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam int CYCLES_SHORT = 1;
    localparam int CYCLES_LONG = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [CTRL_OP_W-1:0] {
        OP_SUM, OP_SUM_CARRY, OP_WORD_SUM, OP_DIFF, OP_DIFF_BORROW,
        OP_WORD_DIFF, OP_BOTH, OP_EITHER, OP_EXCL, OP_ONES_INV,
        OP_TWOS_INV, OP_FORCE_HIGH, OP_FORCE_LOW, OP_PLUS_ONE,
        OP_MINUS_ONE, OP_ZS_CHECK, OP_ZERO_FILL, OP_FILL_ONES,
        OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S,
        OP_FRAC_SU
    } op_type;

    typedef enum logic [1:0] {S_IDLE, S_FIRST, S_SECOND} state_type;

    typedef enum logic [2:0] {
        FL_NONE, FL_LOGIC, FL_COUNT, FL_ARITH, FL_ONES
    } flag_class_type;

    typedef enum logic [2:0] {
        RS_DEST, RS_SRC, RS_WORD_HI, RS_CTRL, RS_FLAGS, RS_PROD_LO,
        RS_PROD_HI, RS_NONE
    } regsel_type;

endpackage : alu_pkg

`default_nettype wire

// *** logic/product_unit.sv ***
`default_nettype none

module product_unit
    import alu_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Operands and mode
    input wire logic load,
    input wire logic [W-1:0] factorA,
    input wire logic [W-1:0] factorB,
    input wire logic signA,
    input wire logic signB,
    input wire logic frac,
    // Result, valid the cycle after load
    output logic [2*W-1:0] product,
    output logic carry
);

    generate
        if (W < 2)
        begin : g_check
            $error("product_unit needs W of at least 2");
        end
    endgenerate

    logic [2*W-1:0] extA;
    logic [2*W-1:0] extB;
    logic [2*W-1:0] fullProd;

    // Sign or zero extension; the whole 2W-bit product is exact
    assign extA = {{W{signA & factorA[W-1]}}, factorA};
    assign extB = {{W{signB & factorB[W-1]}}, factorB};
    assign fullProd = extA * extB;

    // Shift and carry registered so both outputs come from flops
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            product <= '0;
            carry <= 1'b0;
        end
        else if (load)
        begin
            product <= frac ? {fullProd[2*W-2:0], 1'b0} : fullProd;
            carry <= fullProd[2*W-1];
        end
    end

endmodule : product_unit

`default_nettype wire

// *** logic/byte_alu_and_multiplier.sv ***
// Chosen here: the address map and the Wishbone interface to the registers.
`default_nettype none

module byte_alu_and_multiplier
    import alu_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [ADDR_W-1:0] wbAdr,
    input wire logic [DATA_W/8-1:0] wbSel,
    input wire logic [DATA_W-1:0] wbDatW,
    output logic [DATA_W-1:0] wbDatR,
    output logic wbAck
);

    generate
        if (DATA_W < 8 || DATA_W % 8 != 0)
        begin : g_check
            $error("DATA_W must be a whole number of bytes");
        end
    endgenerate

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic regsel_type decodeAddr(input logic [ADDR_W-1:0] a);
        regsel_type rs;
        unique case (a)
            OFF_DEST: rs = RS_DEST;
            OFF_SRC: rs = RS_SRC;
            OFF_WORD_HI: rs = RS_WORD_HI;
            OFF_CTRL: rs = RS_CTRL;
            OFF_FLAGS: rs = RS_FLAGS;
            OFF_PROD_LO: rs = RS_PROD_LO;
            OFF_PROD_HI: rs = RS_PROD_HI;
            default: rs = RS_NONE;
        endcase
        return rs;
    endfunction : decodeAddr

    function automatic logic isLongOp(input op_type op);
        return op inside {OP_WORD_SUM, OP_WORD_DIFF, OP_PROD_U, OP_PROD_S,
            OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU};
    endfunction : isLongOp

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic ackR;
    logic access;
    logic busWrite;
    regsel_type regSel;
    state_type stateR;
    op_type opR;
    logic [7:0] destR;
    logic [7:0] srcR;
    logic [7:0] hiR;
    logic [7:0] flagsR;
    logic [7:0] prodLoR;
    logic [7:0] prodHiR;
    logic [7:0] readByte;
    logic goWrite;

    assign access = wbCyc & wbStb & ~ackR;
    assign regSel = decodeAddr(wbAdr);
    // Operand writes are refused while an operation runs
    assign busWrite = access & wbWe & wbSel[0] & (stateR == S_IDLE);
    assign goWrite = busWrite & (regSel == RS_CTRL)
        & wbDatW[CTRL_GO_BIT];
    assign wbAck = ackR;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ackR <= 1'b0;
        end
        else
        begin
            ackR <= access;
        end
    end

    always_comb
    begin
        unique case (regSel)
            RS_DEST: readByte = destR;
            RS_SRC: readByte = srcR;
            RS_WORD_HI: readByte = hiR;
            RS_CTRL: readByte = {1'b0, stateR != S_IDLE, 1'b0, opR};
            RS_FLAGS: readByte = flagsR;
            RS_PROD_LO: readByte = prodLoR;
            RS_PROD_HI: readByte = prodHiR;
            default: readByte = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wbDatR <= '0;
        end
        else if (access)
        begin
            wbDatR <= {{(DATA_W-8){1'b0}}, readByte};
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stateR <= S_IDLE;
            opR <= OP_SUM;
        end
        else
        begin
            unique case (stateR)
                S_IDLE:
                begin
                    if (goWrite)
                    begin
                        stateR <= S_FIRST;
                        opR <= op_type'(wbDatW[CTRL_OP_W-1:0]);
                    end
                end
                S_FIRST: stateR <= isLongOp(opR) ? S_SECOND : S_IDLE;
                S_SECOND: stateR <= S_IDLE;
                default: stateR <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Byte datapath
    // ************************************************************
    logic [7:0] opA;
    logic [7:0] opB;
    logic cin;
    logic doSub;
    logic [8:0] arith;
    logic [7:0] ar;
    logic halfC;
    logic ovf;
    logic [7:0] byteRes;
    logic [7:0] flagsNxt;
    flag_class_type cls;
    logic writesDest;

    always_comb
    begin
        opA = destR;
        opB = srcR;
        cin = 1'b0;
        doSub = 1'b0;
        case (opR)
            OP_SUM_CARRY: cin = flagsR[FLAG_C];
            OP_DIFF: doSub = 1'b1;
            OP_DIFF_BORROW:
            begin
                doSub = 1'b1;
                cin = flagsR[FLAG_C];
            end
            OP_TWOS_INV:
            begin
                opA = BYTE_ZERO;
                opB = destR;
                doSub = 1'b1;
            end
            OP_PLUS_ONE: opB = BYTE_ONE;
            OP_MINUS_ONE:
            begin
                opB = BYTE_ONE;
                doSub = 1'b1;
            end
            default: ;
        endcase
    end

    assign arith = doSub
        ? ({1'b0, opA} - {1'b0, opB} - {8'h00, cin})
        : ({1'b0, opA} + {1'b0, opB} + {8'h00, cin});
    assign ar = arith[7:0];
    assign halfC = doSub
        ? (~opA[3] & opB[3] | opB[3] & ar[3] | ar[3] & ~opA[3])
        : (opA[3] & opB[3] | opB[3] & ~ar[3] | ~ar[3] & opA[3]);
    assign ovf = doSub
        ? (opA[7] & ~opB[7] & ~ar[7] | ~opA[7] & opB[7] & ar[7])
        : (opA[7] & opB[7] & ~ar[7] | ~opA[7] & ~opB[7] & ar[7]);

    always_comb
    begin
        byteRes = destR;
        cls = FL_NONE;
        writesDest = 1'b1;
        case (opR)
            OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_BORROW, OP_TWOS_INV:
            begin
                byteRes = ar;
                cls = FL_ARITH;
            end
            OP_PLUS_ONE, OP_MINUS_ONE:
            begin
                byteRes = ar;
                cls = FL_COUNT;
            end
            OP_BOTH, OP_ZS_CHECK:
            begin
                byteRes = destR
                    & (opR == OP_ZS_CHECK ? destR : srcR);
                cls = FL_LOGIC;
            end
            OP_EITHER, OP_FORCE_HIGH:
            begin
                byteRes = destR | srcR;
                cls = FL_LOGIC;
            end
            OP_FORCE_LOW:
            begin
                byteRes = destR & (BYTE_ONES - srcR);
                cls = FL_LOGIC;
            end
            OP_EXCL, OP_ZERO_FILL:
            begin
                byteRes = destR
                    ^ (opR == OP_ZERO_FILL ? destR : srcR);
                cls = FL_LOGIC;
            end
            OP_ONES_INV:
            begin
                byteRes = BYTE_ONES - destR;
                cls = FL_ONES;
            end
            OP_FILL_ONES: byteRes = BYTE_ONES;
            default: writesDest = 1'b0;
        endcase
    end

    // Untouched flags pass through unchanged
    always_comb
    begin
        flagsNxt = flagsR;
        if (cls != FL_NONE)
        begin
            flagsNxt[FLAG_Z] = (byteRes == BYTE_ZERO);
            flagsNxt[FLAG_N] = byteRes[7];
            flagsNxt[FLAG_V] = 1'b0;
        end
        case (cls)
            FL_COUNT: flagsNxt[FLAG_V] = ovf;
            FL_ARITH:
            begin
                flagsNxt[FLAG_V] = ovf;
                flagsNxt[FLAG_C] = arith[8];
                flagsNxt[FLAG_H] = halfC;
            end
            FL_ONES: flagsNxt[FLAG_C] = 1'b1;
            default: ;
        endcase
    end

    // ************************************************************
    // Word and product datapath
    // ************************************************************
    logic [15:0] wordResR;
    logic [15:0] product;
    logic prodCarry;
    logic wordOvf;
    logic wordCarry;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wordResR <= 16'h0000;
        end
        else if (stateR == S_FIRST)
        begin
            if (opR == OP_WORD_DIFF)
            begin
                wordResR <= {hiR, destR} - {8'h00, srcR};
            end
            else
            begin
                wordResR <= {hiR, destR} + {8'h00, srcR};
            end
        end
    end

    assign wordOvf = (opR == OP_WORD_DIFF)
        ? (hiR[7] & ~wordResR[15]) : (~hiR[7] & wordResR[15]);
    assign wordCarry = (opR == OP_WORD_DIFF)
        ? (wordResR[15] & ~hiR[7]) : (~wordResR[15] & hiR[7]);

    product_unit #(
        .W(8)
    ) u_product (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load(stateR == S_FIRST),
        .factorA(destR),
        .factorB(srcR),
        .signA(opR inside {OP_PROD_S, OP_PROD_SU, OP_FRAC_S, OP_FRAC_SU}),
        .signB(opR inside {OP_PROD_S, OP_FRAC_S}),
        .frac(opR inside {OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU}),
        .product(product),
        .carry(prodCarry)
    );

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            destR <= DATA_RESET;
            hiR <= DATA_RESET;
            srcR <= DATA_RESET;
        end
        else if (busWrite)
        begin
            if (regSel == RS_DEST)
                destR <= wbDatW[7:0];
            if (regSel == RS_SRC)
                srcR <= wbDatW[7:0];
            if (regSel == RS_WORD_HI)
                hiR <= wbDatW[7:0];
        end
        else if (stateR == S_FIRST && writesDest)
        begin
            destR <= byteRes;
        end
        else if (stateR == S_SECOND && opR inside {OP_WORD_SUM, OP_WORD_DIFF})
        begin
            {hiR, destR} <= wordResR;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prodLoR <= DATA_RESET;
            prodHiR <= DATA_RESET;
        end
        else if (stateR == S_SECOND
            && !(opR inside {OP_WORD_SUM, OP_WORD_DIFF}))
        begin
            {prodHiR, prodLoR} <= product;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            flagsR <= FLAGS_RESET;
        end
        else if (busWrite && regSel == RS_FLAGS)
        begin
            flagsR <= wbDatW[7:0] & FLAGS_MASK;
        end
        else if (stateR == S_FIRST && !isLongOp(opR))
        begin
            flagsR <= flagsNxt;
        end
        else if (stateR == S_SECOND)
        begin
            if (opR inside {OP_WORD_SUM, OP_WORD_DIFF})
            begin
                flagsR[FLAG_Z] <= (wordResR == 16'h0000);
                flagsR[FLAG_N] <= wordResR[15];
                flagsR[FLAG_V] <= wordOvf;
                flagsR[FLAG_C] <= wordCarry;
                flagsR[FLAG_S] <= wordResR[15] ^ wordOvf;
            end
            else
            begin
                flagsR[FLAG_Z] <= (product == 16'h0000);
                flagsR[FLAG_C] <= prodCarry;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_short_done: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && !isLongOp(opR) |=> stateR == S_IDLE)
        else $error("one-cycle operation did not finish in one cycle");

    a_long_done: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && isLongOp(opR)
        |=> stateR == S_SECOND ##1 stateR == S_IDLE)
        else $error("two-cycle operation did not take two cycles");

    a_sum_value: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_SUM
        |=> destR == 8'($past(destR) + $past(srcR)))
        else $error("byte sum wrong");

    a_diff_borrow: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_DIFF
        |=> flagsR[FLAG_C] == ($past(srcR) > $past(destR)))
        else $error("difference borrow wrong");

    a_word_pair: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_WORD_SUM
        |=> ##1 {hiR, destR} == 16'($past({hiR, destR}, 2)
        + {8'h00, $past(srcR, 2)}))
        else $error("word sum wrong");

    a_carry_kept: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR inside {OP_PLUS_ONE, OP_MINUS_ONE}
        |=> $stable(flagsR[FLAG_C]) && $stable(flagsR[FLAG_H]))
        else $error("count operation touched carry");

    a_fill_flags: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_FILL_ONES
        |=> destR == BYTE_ONES && $stable(flagsR))
        else $error("fill ones wrong");

    a_logic_ovf: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_BOTH
        |=> !flagsR[FLAG_V] && destR == ($past(destR) & $past(srcR)))
        else $error("bitwise and wrong");

    a_twos_value: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_TWOS_INV
        |=> destR == 8'(BYTE_ZERO - $past(destR))
        && flagsR[FLAG_C] == ($past(destR) != BYTE_ZERO))
        else $error("twos invert wrong");

    a_prod_value: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stateR == S_FIRST && opR == OP_PROD_U
        |=> ##1 {prodHiR, prodLoR} == ({8'h00, $past(destR, 2)}
        * {8'h00, $past(srcR, 2)}))
        else $error("unsigned product wrong");

    a_ack_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");

endmodule : byte_alu_and_multiplier

`default_nettype wire

// *** test/op_host.sv ***
`default_nettype none

module op_host
    import alu_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Wishbone master side
    output var logic wbCyc,
    output var logic wbStb,
    output var logic wbWe,
    output var logic [ADDR_W-1:0] wbAdr,
    output var logic [3:0] wbSel,
    output var logic [31:0] wbDatW,
    input wire logic [31:0] wbDatR,
    input wire logic wbAck
);
    timeunit 1ns;
    timeprecision 1ns;

    logic timedOut = 1'b0;

    initial
    begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbSel = '0;
        wbDatW = '0;
    end

    // ********************************************************
    // One classic cycle, held until ack is seen
    // ********************************************************
    task access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= dat;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        q = wbDatR;
        if (n >= 50)
            timedOut = 1'b1;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbDatW <= 32'h0;
    endtask : access

endmodule : op_host

`default_nettype wire

// *** test/byte_alu_and_multiplier_test.sv ***
`default_nettype none

module byte_alu_and_multiplier_test;
    import alu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wbCyc, wbStb, wbWe, wbAck;
    logic [ADDR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    int errCount = 0;
    int nCompared = 0;
    // Fields: op, dest, src, word high, flags in, dest/prod lo out,
    // word high/prod hi out, flags out
    logic [63:0] tbl [24] = '{
        64'h00808000_0000000B, 64'h010F0000_01100020,
        64'h02FF017F_2000802C, 64'h03000100_00FF0025,
        64'h04800000_017F0028, 64'h05000100_00FFFF15,
        64'h06F08F00_3F800035, 64'h07000000_0C000002,
        64'h08AA5500_00FF0004, 64'h09000000_20FF0025,
        64'h0A800000_0080000D, 64'h0B018000_01810005,
        64'h0CFF0F00_00F00004, 64'h0D7F0000_0180000D,
        64'h0E010000_00000002, 64'h0F800000_0A800004,
        64'h105A0000_05000003, 64'h11000000_2BFF002B,
        64'h12FFFF00_0001FE01, 64'h13FF0100_0CFFFF0D,
        64'h1480FF00_00808001, 64'h15808000_00008000,
        64'h16005500_01000002, 64'h17FF8000_0000FF01
    };

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    byte_alu_and_multiplier #(.DATA_W(32)) dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
        .wbAck(wbAck));

    op_host host (.sys_clk(sys_clk), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck));

    // ********************************************************
    // Bus tasks and verdict
    // ********************************************************
    task print_verdict;
        if (host.timedOut)
            errCount++;
        if (errCount == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task put(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        logic [31:0] q;
        host.access(1'b1, a, s, {24'h0, d}, q);
        if (host.timedOut)
            print_verdict();
    endtask : put

    task expect_reg(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        host.access(1'b0, a, 4'hF, 32'h0, q);
        if (host.timedOut)
            print_verdict();
        nCompared++;
        if (q !== {24'h0, e})
        begin
            errCount++;
            $display("wrong value reg %h expected %h seen %h", a, e, q);
        end
    endtask : expect_reg

    task wait_idle;
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            host.access(1'b0, OFF_CTRL, 4'hF, 32'h0, q);
            n++;
        end
        while (q[CTRL_BUSY_BIT] !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            errCount++;
            print_verdict();
        end
    endtask : wait_idle

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        logic [7:0] op, d, s, hi, fin, ed, eh, ef;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 8'h1C; a += 4)
            expect_reg(8'(a), 8'h00);
        put(OFF_FLAGS, 8'hFF, 4'hF);
        expect_reg(OFF_FLAGS, FLAGS_MASK);
        put(OFF_DEST, 8'h5A, 4'hE);
        expect_reg(OFF_DEST, 8'h00);
        put(8'h1C, 8'hFF, 4'hF);
        expect_reg(8'h1C, 8'h00);
        put(OFF_PROD_LO, 8'h77, 4'hF);
        expect_reg(OFF_PROD_LO, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            {op, d, s, hi, fin, ed, eh, ef} = tbl[i];
            put(OFF_DEST, d, 4'hF);
            put(OFF_SRC, s, 4'hF);
            put(OFF_WORD_HI, hi, 4'hF);
            put(OFF_FLAGS, fin, 4'hF);
            put(OFF_CTRL, 8'h80 | op, 4'hF);
            wait_idle();
            if (op >= 8'h12)
            begin
                expect_reg(OFF_PROD_LO, ed);
                expect_reg(OFF_PROD_HI, eh);
                expect_reg(OFF_DEST, d);
            end
            else
            begin
                expect_reg(OFF_DEST, ed);
                expect_reg(OFF_WORD_HI, eh);
            end
            expect_reg(OFF_FLAGS, ef);
        end
        // Unused op code: starts, changes nothing, goes idle
        put(OFF_CTRL, 8'h98, 4'hF);
        wait_idle();
        expect_reg(OFF_CTRL, 8'h18);
        expect_reg(OFF_DEST, 8'hFF);
        expect_reg(OFF_FLAGS, 8'h01);
        // Reset while idle clears every register again
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 8'h1C; a += 4)
            expect_reg(8'(a), 8'h00);
        print_verdict();
    end

endmodule : byte_alu_and_multiplier_test

`default_nettype wire
